// ===== rtl/ccd_map.svh
`ifndef CCD_MAP_SVH
`define CCD_MAP_SVH

// Register byte offsets
`define CCD_OFS_MODE_CONTROL   8'h00
`define CCD_OFS_CH1_VALUE      8'h04
`define CCD_OFS_CH2_VALUE      8'h08
`define CCD_OFS_TIMER_COUNT    8'h0C
`define CCD_OFS_TIMER_CONTROL  8'h10
`define CCD_OFS_IRQ_STATUS     8'h14
`define CCD_OFS_IRQ_ENABLE     8'h18
`define CCD_OFS_IRQ_CLEAR      8'h1C

// Field positions
`define CCD_CH1_MODE_LSB       0
`define CCD_CH2_MODE_LSB       4
`define CCD_IRQ_CH1_BIT        0
`define CCD_IRQ_CH2_BIT        1
`define CCD_IRQ_OVF_BIT        2
`define CCD_TIMER_RUN_BIT      0

// Reset values
`define CCD_MODE_RESET         8'h00
`define CCD_VALUE_RESET        16'h0000
`define CCD_TIMER_RESET        16'h0000
`define CCD_IRQ_RESET          3'h0

// Mode codes
`define CCD_MODE_CAP_FALL      4'h4
`define CCD_MODE_CAP_RISE      4'h5
`define CCD_MODE_CAP_RISE4     4'h6
`define CCD_MODE_CAP_RISE16    4'h7
`define CCD_MODE_CMP_SET       4'h8
`define CCD_MODE_CMP_CLEAR     4'h9
`define CCD_MODE_CMP_TOGGLE    4'hA
`define CCD_MODE_RESERVED      4'hB
`define CCD_MODE_CMP_TRIGGER   4'hF

// Capture prescale terminal counts
`define CCD_PRESC_LAST4        4'h3
`define CCD_PRESC_LAST16       4'hF

`endif

// ===== rtl/ccd_pkg.sv
package ccd_pkg;

  typedef logic [3:0] chan_mode_t;

  typedef struct packed {
    logic [15:0] value;
    logic        eq_prev;
    logic        pin_prev;
    logic [3:0]  presc;
    logic        latch;
  } chan_state_t;

  typedef struct packed {
    logic [15:0] count;
  } timer_state_t;

  typedef struct packed {
    logic [7:0]  mode;
    logic        timer_run;
    logic [2:0]  irq_status;
    logic [2:0]  irq_enable;
    logic [31:0] prdata;
    logic        pslverr;
  } regs_state_t;

  function automatic logic mode_is_capture(input chan_mode_t m);
    mode_is_capture = (m[3:2] == 2'b01);
  endfunction

  function automatic logic mode_is_pin_compare(input chan_mode_t m);
    mode_is_pin_compare = (m[3:2] == 2'b10) && (m[1:0] != 2'b11);
  endfunction

  function automatic logic mode_is_compare(input chan_mode_t m);
    mode_is_compare = mode_is_pin_compare(m) || (m[3:2] == 2'b11);
  endfunction

endpackage

// ===== rtl/shared_timer.sv
`timescale 1ns/10ps
`include "ccd_map.svh"
module shared_timer (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        run_i,
  input  wire logic        load_i,
  input  wire logic [15:0] load_data_i,
  output logic      [15:0] count_o,
  output logic             overflow_o
);
  import ccd_pkg::*;

  timer_state_t st_r;
  timer_state_t st_nxt;

  // Only software loads the count; a compare match has no path here
  always_comb begin
    st_nxt = st_r;
    if (load_i) begin
      st_nxt.count = load_data_i;
    end else if (run_i) begin
      st_nxt.count = st_r.count + 16'h0001;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r.count <= `CCD_TIMER_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign count_o    = st_r.count;
  // Overflow comes only from the wrap, never from a trigger
  assign overflow_o = run_i && !load_i && (st_r.count == 16'hFFFF);
endmodule

// ===== rtl/capture_compare_channel.sv
`timescale 1ns/10ps
`include "ccd_map.svh"
module capture_compare_channel (
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  input  wire ccd_pkg::chan_mode_t mode_i,
  input  wire logic [15:0]       timer_i,
  input  wire logic              pin_i,
  input  wire logic              value_we_i,
  input  wire logic [15:0]       value_wdata_i,
  input  wire logic              latch_clear_i,
  input  wire logic              adc_enable_i,
  output logic      [15:0]       value_o,
  output logic                   flag_set_o,
  output logic                   latch_o,
  output logic                   pin_oe_o,
  output logic                   trigger_o
);
  import ccd_pkg::*;

  chan_state_t st_r;
  chan_state_t st_nxt;
  logic        eq;
  logic        match;
  logic        rise;
  logic        fall;
  logic        cap_evt;

  assign eq    = (st_r.value == timer_i);
  // A slow timer holds equality for many cycles; act once per arrival
  assign match = mode_is_compare(mode_i) && eq && !st_r.eq_prev;
  assign rise  = pin_i && !st_r.pin_prev;
  assign fall  = !pin_i && st_r.pin_prev;

  always_comb begin
    cap_evt = 1'b0;
    case (mode_i)
      `CCD_MODE_CAP_FALL:   cap_evt = fall;
      `CCD_MODE_CAP_RISE:   cap_evt = rise;
      `CCD_MODE_CAP_RISE4:  cap_evt = rise && (st_r.presc == `CCD_PRESC_LAST4);
      `CCD_MODE_CAP_RISE16: cap_evt = rise && (st_r.presc == `CCD_PRESC_LAST16);
      default:              cap_evt = 1'b0;
    endcase
  end

  always_comb begin
    st_nxt          = st_r;
    st_nxt.pin_prev = pin_i;
    st_nxt.eq_prev  = eq;
    if (value_we_i) begin
      st_nxt.value = value_wdata_i;
    end
    if (!mode_is_capture(mode_i)) begin
      st_nxt.presc = 4'h0;
    end else if (rise) begin
      // Switching 4th/16th settings keeps the count, so a false capture can occur
      if (cap_evt) begin
        st_nxt.presc = 4'h0;
      end else begin
        st_nxt.presc = st_r.presc + 4'h1;
      end
    end
    if (cap_evt) begin
      st_nxt.value = timer_i;
    end
    if (match) begin
      case (mode_i)
        `CCD_MODE_CMP_SET:    st_nxt.latch = 1'b1;
        `CCD_MODE_CMP_CLEAR:  st_nxt.latch = 1'b0;
        `CCD_MODE_CMP_TOGGLE: st_nxt.latch = !st_r.latch;
        default:              st_nxt.latch = st_r.latch;
      endcase
    end
    if (latch_clear_i || (mode_i[3:2] == 2'b00)) begin
      st_nxt.latch = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r.value    <= `CCD_VALUE_RESET;
      st_r.eq_prev  <= 1'b0;
      st_r.pin_prev <= 1'b0;
      st_r.presc    <= 4'h0;
      st_r.latch    <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign value_o    = st_r.value;
  assign flag_set_o = match || cap_evt;
  assign latch_o    = st_r.latch;
  assign pin_oe_o   = mode_is_pin_compare(mode_i);
  assign trigger_o  = match && (mode_i == `CCD_MODE_CMP_TRIGGER) && adc_enable_i;
endmodule

// ===== rtl/dual_capture_compare_unit.sv
// How it works
// - In compare modes each channel compares its value with the shared timer.
// - A compare match sets the channel flag with the pin action.
// - Writing zero to the mode register clears both output latches and turns both channels off.
// - Trigger mode starts ADC only when enabled and never drives the pin.
// - Trigger output asserts combinationally in the match cycle.
// - Matches and triggers never reset the shared timer.
// - Triggers never set the timer overflow flag.
// - All compare logic runs on the system clock; stopped clock means nothing.
// - Mode register: channel 2 in bits 7-4, channel 1 in 3-0, reset zero.
// - Mode 00xx turns the channel off, clearing prescaler and latch.
// - Capture modes: falling, rising, every 4th, every 16th rising edge.
// - Compare modes set, clear or toggle output and set the flag.
// - 1011 reserved; 11xx except 1111 only sets the flag.
// - Mode 1111 sets flag, triggers ADC if enabled, leaves pin alone.
// - A capture copies the timer into the value register and sets flag.
// - Prescaler clears when off, not capturing or reset; not on prescale change.
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/10ps
`include "ccd_map.svh"
module dual_capture_compare_unit (
  input  wire logic        SYS_CLK_I,
  input  wire logic        RSTN_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic             PREADY_O,
  output logic      [31:0] PRDATA_O,
  output logic             PSLVERR_O,
  input  wire logic        CH1_PIN_I,
  input  wire logic        CH2_PIN_I,
  output logic             CH1_PIN_O,
  output logic             CH1_PIN_OE_O,
  output logic             CH2_PIN_O,
  output logic             CH2_PIN_OE_O,
  input  wire logic        ADC_ENABLE_I,
  output logic             ADC_START_O,
  output logic             IRQ_O
);
  import ccd_pkg::*;

  regs_state_t st_r;
  regs_state_t st_nxt;

  logic        wr_acc;
  logic        rd_setup;
  logic        addr_ok;
  logic [15:0] timer_count;
  logic        timer_ovf;
  logic [15:0] ch1_value;
  logic [15:0] ch2_value;
  logic        ch1_flag_set;
  logic        ch2_flag_set;
  logic        ch1_trigger;
  logic        ch2_trigger;
  logic        latch_clear;
  logic        ch1_we;
  logic        ch2_we;
  logic        timer_load;
  logic [2:0]  irq_set;
  logic [2:0]  irq_clr;
  logic [31:0] rd_mux;

  // A write takes effect in the access phase; read data is captured in setup
  assign wr_acc   = PSEL_I && PENABLE_I && PWRITE_I;
  assign rd_setup = PSEL_I && !PENABLE_I;

  always_comb begin
    case (PADDR_I)
      `CCD_OFS_MODE_CONTROL,
      `CCD_OFS_CH1_VALUE,
      `CCD_OFS_CH2_VALUE,
      `CCD_OFS_TIMER_COUNT,
      `CCD_OFS_TIMER_CONTROL,
      `CCD_OFS_IRQ_STATUS,
      `CCD_OFS_IRQ_ENABLE,
      `CCD_OFS_IRQ_CLEAR:    addr_ok = 1'b1;
      default:               addr_ok = 1'b0;
    endcase
  end

  assign ch1_we      = wr_acc && (PADDR_I == `CCD_OFS_CH1_VALUE);
  assign ch2_we      = wr_acc && (PADDR_I == `CCD_OFS_CH2_VALUE);
  assign timer_load  = wr_acc && (PADDR_I == `CCD_OFS_TIMER_COUNT);
  // A write of the whole register as zero clears both latches at once; a channel in mode 00xx also clears its own
  assign latch_clear = wr_acc && (PADDR_I == `CCD_OFS_MODE_CONTROL) && (PWDATA_I[7:0] == 8'h00);

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (PADDR_I)
      `CCD_OFS_MODE_CONTROL:  rd_mux = {24'h00_0000, st_r.mode};
      `CCD_OFS_CH1_VALUE:     rd_mux = {16'h0000, ch1_value};
      `CCD_OFS_CH2_VALUE:     rd_mux = {16'h0000, ch2_value};
      `CCD_OFS_TIMER_COUNT:   rd_mux = {16'h0000, timer_count};
      `CCD_OFS_TIMER_CONTROL: rd_mux = {31'h0000_0000, st_r.timer_run};
      `CCD_OFS_IRQ_STATUS:    rd_mux = {29'h0000_0000, st_r.irq_status};
      `CCD_OFS_IRQ_ENABLE:    rd_mux = {29'h0000_0000, st_r.irq_enable};
      default:                rd_mux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    irq_set                    = 3'h0;
    irq_set[`CCD_IRQ_CH1_BIT]  = ch1_flag_set;
    irq_set[`CCD_IRQ_CH2_BIT]  = ch2_flag_set;
    irq_set[`CCD_IRQ_OVF_BIT]  = timer_ovf;
    irq_clr = 3'h0;
    if (wr_acc && (PADDR_I == `CCD_OFS_IRQ_CLEAR)) begin
      irq_clr = PWDATA_I[2:0];
    end
  end

  always_comb begin
    st_nxt = st_r;
    if (wr_acc) begin
      case (PADDR_I)
        `CCD_OFS_MODE_CONTROL:  st_nxt.mode = PWDATA_I[7:0];
        `CCD_OFS_TIMER_CONTROL: st_nxt.timer_run = PWDATA_I[`CCD_TIMER_RUN_BIT];
        `CCD_OFS_IRQ_ENABLE:    st_nxt.irq_enable = PWDATA_I[2:0];
        default:                st_nxt.mode = st_r.mode;
      endcase
    end
    // A flag event in the clearing cycle survives the clear
    st_nxt.irq_status = (st_r.irq_status & ~irq_clr) | irq_set;
    if (rd_setup) begin
      st_nxt.prdata  = PWRITE_I ? 32'h0000_0000 : rd_mux;
      st_nxt.pslverr = !addr_ok;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      st_r.mode       <= `CCD_MODE_RESET;
      st_r.timer_run  <= 1'b0;
      st_r.irq_status <= `CCD_IRQ_RESET;
      st_r.irq_enable <= `CCD_IRQ_RESET;
      st_r.prdata     <= 32'h0000_0000;
      st_r.pslverr    <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Timer count is only loaded by software; channels have no reset path to it
  shared_timer u_timer (
    .clk_i       (SYS_CLK_I),
    .rstn_i      (RSTN_I),
    .run_i       (st_r.timer_run),
    .load_i      (timer_load),
    .load_data_i (PWDATA_I[15:0]),
    .count_o     (timer_count),
    .overflow_o  (timer_ovf)
  );

  capture_compare_channel u_ch1 (
    .clk_i         (SYS_CLK_I),
    .rstn_i        (RSTN_I),
    .mode_i        (st_r.mode[`CCD_CH1_MODE_LSB +: 4]),
    .timer_i       (timer_count),
    .pin_i         (CH1_PIN_I),
    .value_we_i    (ch1_we),
    .value_wdata_i (PWDATA_I[15:0]),
    .latch_clear_i (latch_clear),
    .adc_enable_i  (ADC_ENABLE_I),
    .value_o       (ch1_value),
    .flag_set_o    (ch1_flag_set),
    .latch_o       (CH1_PIN_O),
    .pin_oe_o      (CH1_PIN_OE_O),
    .trigger_o     (ch1_trigger)
  );

  capture_compare_channel u_ch2 (
    .clk_i         (SYS_CLK_I),
    .rstn_i        (RSTN_I),
    .mode_i        (st_r.mode[`CCD_CH2_MODE_LSB +: 4]),
    .timer_i       (timer_count),
    .pin_i         (CH2_PIN_I),
    .value_we_i    (ch2_we),
    .value_wdata_i (PWDATA_I[15:0]),
    .latch_clear_i (latch_clear),
    .adc_enable_i  (ADC_ENABLE_I),
    .value_o       (ch2_value),
    .flag_set_o    (ch2_flag_set),
    .latch_o       (CH2_PIN_O),
    .pin_oe_o      (CH2_PIN_OE_O),
    .trigger_o     (ch2_trigger)
  );

  // Zero-wait slave; the pin direction itself is outside this block
  assign PREADY_O    = 1'b1;
  assign PRDATA_O    = st_r.prdata;
  assign PSLVERR_O   = PSEL_I && PENABLE_I && st_r.pslverr;
  assign ADC_START_O = ch1_trigger || ch2_trigger;
  assign IRQ_O       = |(st_r.irq_status & st_r.irq_enable);
endmodule

// ===== verification/ccd_props.sv
`timescale 1ns/10ps
module ccd_props (
  input wire logic        SYS_CLK_I,
  input wire logic        RSTN_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [7:0]  PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PSLVERR_O,
  input wire logic        CH1_PIN_O,
  input wire logic        CH1_PIN_OE_O,
  input wire logic        CH2_PIN_O,
  input wire logic        CH2_PIN_OE_O,
  input wire logic        ADC_ENABLE_I,
  input wire logic        ADC_START_O
);
  logic [7:0] mode_r;
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RSTN_I);
  // Shadow of the mode register, taken on the same access edge as the block
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      mode_r <= 8'h00;
    end else if (PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == 8'h00) begin
      mode_r <= PWDATA_I[7:0];
    end
  end
  sequence mode_rd_s;
    PSEL_I && !PENABLE_I && !PWRITE_I && PADDR_I == 8'h00 ##1 PSEL_I && PENABLE_I;
  endsequence
  sequence ch2_off_s;
    (mode_r[7:6] == 2'b00) [*2];
  endsequence
  mode_read_a: assert property (mode_rd_s |-> PRDATA_O == {24'h00_0000, mode_r})
    else $error("mode readback differs");
  bad_addr_a: assert property (PSEL_I && PENABLE_I |-> PSLVERR_O == (PADDR_I[1:0] != 2'b00 || PADDR_I > 8'h1C))
    else $error("slave error decode wrong");
  oe_one_a: assert property (CH1_PIN_OE_O == (mode_r[3:2] == 2'b10 && mode_r[1:0] != 2'b11))
    else $error("channel 1 pin enable wrong");
  oe_two_a: assert property (CH2_PIN_OE_O == (mode_r[7:6] == 2'b10 && mode_r[5:4] != 2'b11))
    else $error("channel 2 pin enable wrong");
  adc_gate_a: assert property (ADC_START_O |-> ADC_ENABLE_I && (mode_r[3:0] == 4'hF || mode_r[7:4] == 4'hF))
    else $error("conversion start without cause");
  set_cause_a: assert property ($rose(CH1_PIN_O) |-> $past(mode_r[3:0]) inside {4'h8, 4'hA})
    else $error("latch set in wrong mode");
  clear_cause_a: assert property ($fell(CH1_PIN_O) |-> $past(mode_r[3:0]) inside {4'h9, 4'hA} || mode_r[3:2] == 2'b00)
    else $error("latch cleared in wrong mode");
  off_low_a: assert property (ch2_off_s |-> !CH2_PIN_O)
    else $error("latch high while channel off");
endmodule
bind dual_capture_compare_unit ccd_props chk (.SYS_CLK_I, .RSTN_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I,
  .PWDATA_I, .PRDATA_O, .PSLVERR_O, .CH1_PIN_O, .CH1_PIN_OE_O, .CH2_PIN_O, .CH2_PIN_OE_O, .ADC_ENABLE_I,
  .ADC_START_O);

// ===== verification/far_side_model.sv
`timescale 1ns/10ps
module far_side_model (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic ext1_i,
  input  wire logic ext2_i,
  input  wire logic out1_i,
  input  wire logic oe1_i,
  input  wire logic out2_i,
  input  wire logic oe2_i,
  input  wire logic start_i,
  output logic      pin1_o,
  output logic      pin2_o,
  output int        conv_count_o
);
  // Pin wire: the block's driver wins once the pin is an output
  assign pin1_o = oe1_i ? out1_i : ext1_i;
  assign pin2_o = oe2_i ? out2_i : ext2_i;
  // Every start is counted, so a stray pulse shows even with the converter off
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      conv_count_o <= 0;
    end else if (start_i) begin
      conv_count_o <= conv_count_o + 1;
    end
  end
endmodule

// ===== verification/tb.sv
`timescale 1ns/10ps
`include "ccd_map.svh"
module tb;
  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] e;
    logic        err;
  } reg_row_t;
  typedef struct packed {
    logic [3:0] mode;
    logic       adc;
    logic       pin;
    logic       oe;
    logic       flag;
    logic [1:0] conv;
  } cmp_row_t;
  localparam logic [7:0] a_mode = `CCD_OFS_MODE_CONTROL;
  localparam logic [7:0] a_v1   = `CCD_OFS_CH1_VALUE;
  localparam logic [7:0] a_v2   = `CCD_OFS_CH2_VALUE;
  localparam logic [7:0] a_tmr  = `CCD_OFS_TIMER_COUNT;
  localparam logic [7:0] a_ctl  = `CCD_OFS_TIMER_CONTROL;
  localparam logic [7:0] a_st   = `CCD_OFS_IRQ_STATUS;
  localparam logic [7:0] a_en   = `CCD_OFS_IRQ_ENABLE;
  localparam logic [7:0] a_clr  = `CCD_OFS_IRQ_CLEAR;
  logic        clk, rstn, psel, penable, pwrite, pready, pslverr, rerr;
  logic        ext1, ext2, pin1, pin2, out1, oe1, out2, oe2, adc_en, adc_start, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdata;
  int          conv, n, cycles, mismatches, cmp_count;
  reg_row_t regs [11] = '{
    '{8'h04, 32'hFFFF_0010, 32'h0000_0010, 1'b0}, '{8'h08, 32'h1234_BEEF, 32'h0000_BEEF, 1'b0},
    '{8'h0C, 32'h0000_1234, 32'h0000_1234, 1'b0}, '{8'h00, 32'hFFFF_FF5A, 32'h0000_005A, 1'b0},
    '{8'h00, 32'h0000_0000, 32'h0000_0000, 1'b0}, '{8'h14, 32'h0000_0007, 32'h0000_0000, 1'b0},
    '{8'h1C, 32'h0000_0007, 32'h0000_0000, 1'b0}, '{8'h18, 32'hFFFF_FFFF, 32'h0000_0007, 1'b0},
    '{8'h18, 32'h0000_0000, 32'h0000_0000, 1'b0}, '{8'h20, 32'h0000_0000, 32'h0000_0000, 1'b1},
    '{8'h02, 32'h0000_0000, 32'h0000_0000, 1'b1}};
  cmp_row_t cmp [7] = '{'{4'h8, 1'b1, 1'b1, 1'b1, 1'b1, 2'h0}, '{4'h9, 1'b1, 1'b0, 1'b1, 1'b1, 2'h0},
    '{4'hA, 1'b1, 1'b1, 1'b1, 1'b1, 2'h0}, '{4'hC, 1'b1, 1'b1, 1'b0, 1'b1, 2'h0},
    '{4'hF, 1'b1, 1'b1, 1'b0, 1'b1, 2'h1}, '{4'hF, 1'b0, 1'b1, 1'b0, 1'b1, 2'h0},
    '{4'hB, 1'b1, 1'b1, 1'b0, 1'b0, 2'h0}};
  dual_capture_compare_unit uut (.SYS_CLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PREADY_O(pready), .PRDATA_O(prdata),
    .PSLVERR_O(pslverr), .CH1_PIN_I(pin1), .CH2_PIN_I(pin2), .CH1_PIN_O(out1), .CH1_PIN_OE_O(oe1),
    .CH2_PIN_O(out2), .CH2_PIN_OE_O(oe2), .ADC_ENABLE_I(adc_en), .ADC_START_O(adc_start), .IRQ_O(irq));
  far_side_model far (.clk_i(clk), .rstn_i(rstn), .ext1_i(ext1), .ext2_i(ext2), .out1_i(out1), .oe1_i(oe1),
    .out2_i(out2), .oe2_i(oe2), .start_i(adc_start), .pin1_o(pin1), .pin2_o(pin2), .conv_count_o(conv));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      results();
    end
  end
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic chkb(input string s, input logic e, input logic g);
    chk(s, {31'h0000_0000, e}, {31'h0000_0000, g});
  endtask
  // Request held until pready is seen high; read data taken at that edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input string s, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(s, e, rdata);
  endtask
  // Pin is held three cycles each way so the block's sampler sees both levels
  task automatic pulse(input int k);
    repeat (k) begin
      ext1 <= 1'b1;
      repeat (3) @(posedge clk);
      ext1 <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata, ext1, ext2, adc_en} = '0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    chk("idle outputs", 32'h0000_0000, {25'h000_0000, out1, oe1, out2, oe2, adc_start, irq, pslverr});
    for (int i = 0; i < 32; i += 4) begin
      rdc("reset value", i[7:0], 32'h0000_0000);
    end
    foreach (regs[i]) begin
      wr(regs[i].a, regs[i].d);
      apb(1'b0, regs[i].a, 32'h0000_0000);
      chk("readback", regs[i].e, rdata);
      chkb("slave error", regs[i].err, rerr);
    end
    foreach (cmp[i]) begin
      adc_en <= cmp[i].adc;
      wr(a_mode, {28'h000_0000, cmp[i].mode});
      wr(a_tmr, 32'h0000_000C);
      n = conv;
      wr(a_ctl, 32'h0000_0001);
      repeat (12) @(posedge clk);
      wr(a_ctl, 32'h0000_0000);
      chkb("pin level", cmp[i].pin, out1);
      chkb("pin enable", cmp[i].oe, oe1);
      chk("conversions", {30'h0000_0000, cmp[i].conv}, conv - n);
      rdc("status", a_st, {31'h0000_0000, cmp[i].flag});
      apb(1'b0, a_tmr, 32'h0000_0000);
      chkb("timer past match", 1'b1, rdata > 32'h0000_0010);
      wr(a_clr, 32'h0000_0007);
    end
    wr(a_mode, 32'h0000_0000);
    repeat (2) @(posedge clk);
    chkb("latch cleared", 1'b0, out1);
    wr(a_mode, 32'h0000_0045);
    wr(a_tmr, 32'h0000_0100);
    {ext1, ext2} <= 2'b11;
    repeat (4) @(posedge clk);
    wr(a_tmr, 32'h0000_0200);
    rdc("rise capture", a_v1, 32'h0000_0100);
    rdc("fall ignores rise", a_v2, 32'h0000_BEEF);
    {ext1, ext2} <= 2'b00;
    repeat (4) @(posedge clk);
    rdc("rise ignores fall", a_v1, 32'h0000_0100);
    rdc("fall capture", a_v2, 32'h0000_0200);
    rdc("capture flags", a_st, 32'h0000_0003);
    wr(a_en, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chkb("irq raised", 1'b1, irq);
    wr(a_clr, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chkb("irq cleared", 1'b0, irq);
    wr(a_en, 32'h0000_0002);
    repeat (2) @(posedge clk);
    chkb("irq second flag", 1'b1, irq);
    wr(a_en, 32'h0000_0000);
    repeat (2) @(posedge clk);
    chkb("irq masked", 1'b0, irq);
    wr(a_clr, 32'h0000_0007);
    wr(a_mode, 32'h0000_0006);
    wr(a_tmr, 32'h0000_0300);
    pulse(3);
    rdc("third edge ignored", a_v1, 32'h0000_0100);
    pulse(1);
    rdc("fourth edge", a_v1, 32'h0000_0300);
    pulse(2);
    wr(a_mode, 32'h0000_0000);
    wr(a_mode, 32'h0000_0006);
    wr(a_tmr, 32'h0000_0400);
    pulse(2);
    rdc("count cleared when off", a_v1, 32'h0000_0300);
    pulse(2);
    rdc("count restarts", a_v1, 32'h0000_0400);
    pulse(2);
    wr(a_mode, 32'h0000_0007);
    wr(a_tmr, 32'h0000_0500);
    pulse(13);
    rdc("count kept on change", a_v1, 32'h0000_0400);
    pulse(1);
    rdc("sixteenth edge", a_v1, 32'h0000_0500);
    wr(a_mode, 32'h0000_0080);
    wr(a_v2, 32'h0000_0001);
    wr(a_tmr, 32'h0000_FFFE);
    wr(a_clr, 32'h0000_0007);
    wr(a_ctl, 32'h0000_0001);
    repeat (8) @(posedge clk);
    wr(a_ctl, 32'h0000_0000);
    chkb("pin two level", 1'b1, out2);
    chkb("pin two enable", 1'b1, oe2);
    chkb("pin one off", 1'b0, out1);
    rdc("wrap and match", a_st, 32'h0000_0006);
    // Mid-run reset must drop pin two, irq and slave error outputs and the mode, status and timer registers back to idle
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    chk("reset outputs", 32'h0000_0000, {28'h000_0000, out2, oe2, irq, pslverr});
    rstn <= 1'b1;
    rdc("mode after reset", a_mode, 32'h0000_0000);
    rdc("status after reset", a_st, 32'h0000_0000);
    rdc("timer after reset", a_tmr, 32'h0000_0000);
    results();
  end
endmodule
